// file: ealc_pkg.sv
// ****************************************************************
// e1 alarm response and loopback control constants
// ****************************************************************
package ealc_pkg;

  // register offsets, channel 1 copy
  localparam logic [11:0] ADDR_RESET_LOOP = 12'h0105;
  localparam logic [11:0] ADDR_TEST_CTRL = 12'h0106;
  localparam logic [11:0] ADDR_SYS_AIS_CTRL = 12'h0107;
  localparam logic [11:0] ADDR_STATUS = 12'h0110;
  localparam logic [11:0] ADDR_ALARM_EN = 12'h011a;

  // channel_reset_loopback_ctrl fields
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_FORCE_ONES = 2;
  localparam int BIT_REMOTE_LOOP = 1;
  localparam int BIT_LOCAL_LOOP = 0;
  localparam logic [7:0] MASK_RESET_LOOP = 8'h87;

  // alarm_response_enable_ctrl fields
  localparam int BIT_AUTO_MF = 7;
  localparam int BIT_AUTO_RA = 6;
  localparam int BIT_STAT_SLOT0 = 5;
  localparam int BIT_STAT_SLOT16 = 4;
  localparam int BIT_OOM_CRC = 3;
  localparam int BIT_OOM_S16 = 2;
  localparam int BIT_AIS_S16 = 1;
  localparam int BIT_AIS_LINE = 0;

  // manual alarm bits in the test and system ais registers
  localparam int BIT_MANUAL_MF = 5;
  localparam int BIT_MANUAL_RA = 2;

  // status register fields
  localparam int BIT_STAT_REMOTE = 4;
  localparam int BIT_STAT_OOM = 3;
  localparam int BIT_STAT_AIS = 2;

  // reset value and forced ones bit
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic ALL_ONES_BIT = 1'h1;

  // whole state of the block
  typedef struct packed {
    logic [7:0] reset_loop;
    logic [7:0] alarm_en;
    logic manual_mf;
    logic manual_ra;
    logic remote_status;
    logic oom;
    logic ais;
    logic tx_ra;
    logic tx_mf;
    logic tx_frame;
    logic tx_line;
    logic rx_line;
    logic [7:0] rdata;
  } ealc_state_t;

endpackage : ealc_pkg

// file: ealc_ctrl.sv

`timescale 1ns/1ps

// ****************************************************************
// per-channel alarm response and loopback control
// ****************************************************************
module ealc_ctrl (
  input wire logic CLOCK,
  input wire logic RST,
  // microprocessor port
  input wire logic [11:0] CPU_ADDR,
  input wire logic [7:0] CPU_WDATA,
  input wire logic CPU_WR,
  input wire logic CPU_RD,
  output logic [7:0] CPU_RDATA,
  // receive framer conditions
  input wire logic RX_FRAME_LOSS,
  input wire logic RX_S16_MF_LOSS,
  input wire logic RX_CRC_MF_LOSS,
  input wire logic RX_LINE_AIS,
  input wire logic RX_S16_AIS,
  input wire logic RX_SLOT0_REMOTE_SEEN,
  input wire logic RX_SLOT16_REMOTE_SEEN,
  // transmit frame stream before the encoder
  input wire logic TX_FRAME_IN,
  input wire logic TX_Y_BIT_SLOT,
  input wire logic TX_RA_BIT_SLOT,
  output logic TX_FRAME_OUT,
  // line side
  input wire logic RX_LINE_IN,
  input wire logic TX_LINE_IN,
  output logic TX_LINE_OUT,
  output logic RX_LINE_OUT,
  // alarm levels
  output logic REMOTE_MF_ALARM_TX,
  output logic REMOTE_ALARM_TX,
  output logic REMOTE_ALARM_STATUS,
  output logic OOM_ALARM,
  output logic AIS_ALARM,
  output logic CHANNEL_IN_RESET
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // address match, used by both the write and read decode
  // one compare for both paths, so a write and a read never disagree on a hit
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    addr_hit = (addr == off);
  endfunction : addr_hit

  // whole block state lives in one registered struct
  ealc_pkg::ealc_state_t state;
  ealc_pkg::ealc_state_t next_state;

  // decoded control fields
  logic soft_reset;
  logic auto_mf_en;
  logic auto_ra_en;
  logic stat_slot0_en;
  logic stat_slot16_en;
  logic oom_crc_en;
  logic oom_s16_en;
  logic ais_s16_en;
  logic ais_line_en;
  logic force_ones;
  logic remote_loop;
  logic local_loop;
  // live alarm conditions
  logic oom_cond;
  logic ais_cond;
  logic remote_seen;
  logic mf_alarm_value;
  logic ra_alarm_value;
  // read path
  logic status_read;
  logic [7:0] status_byte;
  logic [7:0] read_mux;
  // line path
  logic tx_line_value;

  // ****************************************************************
  // field extraction
  // ****************************************************************

  // control bits taken from the two configuration registers
  // reserved positions of the reset register are never decoded
  assign soft_reset = state.reset_loop[ealc_pkg::BIT_SOFT_RESET];
  assign force_ones = state.reset_loop[ealc_pkg::BIT_FORCE_ONES];
  assign remote_loop = state.reset_loop[ealc_pkg::BIT_REMOTE_LOOP];
  assign local_loop = state.reset_loop[ealc_pkg::BIT_LOCAL_LOOP];
  assign auto_mf_en = state.alarm_en[ealc_pkg::BIT_AUTO_MF];
  assign auto_ra_en = state.alarm_en[ealc_pkg::BIT_AUTO_RA];
  assign stat_slot0_en = state.alarm_en[ealc_pkg::BIT_STAT_SLOT0];
  assign stat_slot16_en = state.alarm_en[ealc_pkg::BIT_STAT_SLOT16];
  assign oom_crc_en = state.alarm_en[ealc_pkg::BIT_OOM_CRC];
  assign oom_s16_en = state.alarm_en[ealc_pkg::BIT_OOM_S16];
  assign ais_s16_en = state.alarm_en[ealc_pkg::BIT_AIS_S16];
  assign ais_line_en = state.alarm_en[ealc_pkg::BIT_AIS_LINE];

  // ****************************************************************
  // alarm conditions
  // ****************************************************************

  // out of multiframe from the enabled causes
  // the enables combine as independent ors, so either one alone counts
  assign oom_cond = (oom_crc_en & RX_CRC_MF_LOSS)
    | (oom_s16_en & RX_S16_MF_LOSS);

  // ais alarm, silent with both enables clear
  // neither term can rise while both enables are clear
  assign ais_cond = (ais_line_en & RX_LINE_AIS)
    | (ais_s16_en & RX_S16_AIS);

  // remote alarm detection from either slot
  assign remote_seen = (stat_slot0_en & RX_SLOT0_REMOTE_SEEN)
    | (stat_slot16_en & RX_SLOT16_REMOTE_SEEN);

  // transmitted alarm bits, automatic part follows the live loss
  // the automatic part is not latched: once the receive side realigns the
  // bit falls back to the manual value on the next clock
  assign mf_alarm_value = state.manual_mf
    | (auto_mf_en & oom_cond);
  assign ra_alarm_value = state.manual_ra
    | (auto_ra_en & RX_FRAME_LOSS);

  // ****************************************************************
  // read path
  // ****************************************************************

  // a read of the status register also clears the sticky remote flag
  assign status_read = CPU_RD & addr_hit(CPU_ADDR, ealc_pkg::ADDR_STATUS);

  // status byte, unused bits read zero
  // oom and ais are live levels, only the remote flag is sticky
  always_comb
  begin
    status_byte = ealc_pkg::RESET_BYTE;
    status_byte[ealc_pkg::BIT_STAT_REMOTE] = state.remote_status;
    status_byte[ealc_pkg::BIT_STAT_OOM] = state.oom;
    status_byte[ealc_pkg::BIT_STAT_AIS] = state.ais;
  end

  // register read selection, unmapped addresses read zero
  always_comb
  begin
    read_mux = ealc_pkg::RESET_BYTE;
    if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_RESET_LOOP))
    begin
      read_mux = state.reset_loop;
    end
    else if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_ALARM_EN))
    begin
      read_mux = state.alarm_en;
    end
    else if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_TEST_CTRL))
    begin
      read_mux[ealc_pkg::BIT_MANUAL_MF] = state.manual_mf;
    end
    else if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_SYS_AIS_CTRL))
    begin
      read_mux[ealc_pkg::BIT_MANUAL_RA] = state.manual_ra;
    end
    else if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_STATUS))
    begin
      read_mux = status_byte;
    end
  end

  // ****************************************************************
  // line path
  // ****************************************************************

  // line output: remote loopback wins, then forced ones, then data
  // remote loopback takes the raw receive bit ahead of the decoder, so the
  // forced ones setting acts on the local transmit path only
  always_comb
  begin
    if (remote_loop)
    begin
      tx_line_value = RX_LINE_IN;
    end
    else if (force_ones)
    begin
      tx_line_value = ealc_pkg::ALL_ONES_BIT;
    end
    else
    begin
      tx_line_value = TX_LINE_IN;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  // one combinational copy of the state, registered below
  always_comb
  begin
    next_state = state;

    // register writes
    // reserved bits of the reset register are stored as zero
    if (CPU_WR)
    begin
      if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_RESET_LOOP))
      begin
        next_state.reset_loop = CPU_WDATA & ealc_pkg::MASK_RESET_LOOP;
      end
      if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_ALARM_EN))
      begin
        next_state.alarm_en = CPU_WDATA;
      end
      if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_TEST_CTRL))
      begin
        next_state.manual_mf = CPU_WDATA[ealc_pkg::BIT_MANUAL_MF];
      end
      if (addr_hit(CPU_ADDR, ealc_pkg::ADDR_SYS_AIS_CTRL))
      begin
        next_state.manual_ra = CPU_WDATA[ealc_pkg::BIT_MANUAL_RA];
      end
    end

    // read data, captured on the read strobe
    // a write in the same cycle lands after the read, so the old value returns
    if (CPU_RD)
    begin
      next_state.rdata = read_mux;
    end

    // sticky remote status: clear on read, a new detection wins
    // a detection in the same cycle as the read keeps the flag set
    if (status_read)
    begin
      next_state.remote_status = 1'h0;
    end
    if (remote_seen)
    begin
      next_state.remote_status = 1'h1;
    end

    // live alarm levels
    next_state.oom = oom_cond;
    next_state.ais = ais_cond;

    // transmit alarm bits and inserted frame stream
    // the two marked positions never coincide on the line; slot 16 is tested
    // first only to keep the selection a plain priority chain
    next_state.tx_mf = mf_alarm_value;
    next_state.tx_ra = ra_alarm_value;
    if (TX_Y_BIT_SLOT)
    begin
      next_state.tx_frame = TX_FRAME_IN | mf_alarm_value;
    end
    else if (TX_RA_BIT_SLOT)
    begin
      next_state.tx_frame = TX_FRAME_IN | ra_alarm_value;
    end
    else
    begin
      next_state.tx_frame = TX_FRAME_IN;
    end

    // line side registers
    // local loopback sends the encoded transmit bit back towards the decoder
    next_state.tx_line = tx_line_value;
    if (local_loop)
    begin
      next_state.rx_line = TX_LINE_IN;
    end
    else
    begin
      next_state.rx_line = RX_LINE_IN;
    end

    // channel held initialised while soft reset is set
    // control registers survive, so software clears the bit and resumes
    // without reprogramming; read data is left alone so a read completes
    if (soft_reset)
    begin
      next_state.remote_status = 1'h0;
      next_state.oom = 1'h0;
      next_state.ais = 1'h0;
      next_state.tx_mf = 1'h0;
      next_state.tx_ra = 1'h0;
      next_state.tx_frame = 1'h0;
      next_state.tx_line = 1'h0;
      next_state.rx_line = 1'h0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // synchronous reset clears every field, outputs included
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // all outputs come straight from the state register
  // read data holds until the next read strobe replaces it
  assign CPU_RDATA = state.rdata;
  assign TX_FRAME_OUT = state.tx_frame;
  assign TX_LINE_OUT = state.tx_line;
  assign RX_LINE_OUT = state.rx_line;
  assign REMOTE_MF_ALARM_TX = state.tx_mf;
  assign REMOTE_ALARM_TX = state.tx_ra;
  assign REMOTE_ALARM_STATUS = state.remote_status;
  assign OOM_ALARM = state.oom;
  assign AIS_ALARM = state.ais;
  assign CHANNEL_IN_RESET = soft_reset;

endmodule : ealc_ctrl

// file: ealc_far_end.sv
`timescale 1ns/1ps
// ****************************************************************
// far-end line equipment: raw receive bit stream
// ****************************************************************
module ealc_far_end (
  input wire logic clock,
  input wire logic rst,
  output logic line_out
);
  logic [2:0] cnt;

  // pattern changes after the rising edge so it never races the sampling edge
  always_ff @(posedge clock)
  begin
    cnt <= rst ? 3'h0 : cnt + 3'h1;
    line_out <= rst ? 1'b0 : ~line_out ^ (cnt == 3'h5);
  end
endmodule : ealc_far_end

// file: ealc_ctrl_chk.sv
`timescale 1ns/1ps
// ****************************************************************
// port checker for alarm response and loopback control
// ****************************************************************
module ealc_chk (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [11:0] CPU_ADDR,
  input wire logic [7:0] CPU_WDATA,
  input wire logic CPU_WR,
  input wire logic RX_FRAME_LOSS,
  input wire logic RX_S16_MF_LOSS,
  input wire logic RX_CRC_MF_LOSS,
  input wire logic RX_LINE_AIS,
  input wire logic RX_S16_AIS,
  input wire logic RX_SLOT0_REMOTE_SEEN,
  input wire logic RX_SLOT16_REMOTE_SEEN,
  input wire logic TX_FRAME_IN,
  input wire logic TX_Y_BIT_SLOT,
  input wire logic TX_RA_BIT_SLOT,
  input wire logic TX_FRAME_OUT,
  input wire logic RX_LINE_IN,
  input wire logic TX_LINE_IN,
  input wire logic TX_LINE_OUT,
  input wire logic RX_LINE_OUT,
  input wire logic REMOTE_MF_ALARM_TX,
  input wire logic REMOTE_ALARM_TX,
  input wire logic REMOTE_ALARM_STATUS,
  input wire logic OOM_ALARM,
  input wire logic AIS_ALARM,
  input wire logic CHANNEL_IN_RESET
);
  logic [7:0] en;
  logic [3:0] c5;
  logic m6;
  logic m7;
  wire logic oc = (en[3] & RX_CRC_MF_LOSS) | (en[2] & RX_S16_MF_LOSS);
  wire logic run = !RST && !c5[3];

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  // shadow of the control registers, taken from the write strobe
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      {en, c5, m6, m7} <= 14'h0000;
    end
    else if (CPU_WR)
    begin
      case (CPU_ADDR)
        ealc_pkg::ADDR_ALARM_EN: en <= CPU_WDATA;
        ealc_pkg::ADDR_RESET_LOOP: c5 <= {CPU_WDATA[7], CPU_WDATA[2:0]};
        ealc_pkg::ADDR_TEST_CTRL: m6 <= CPU_WDATA[5];
        ealc_pkg::ADDR_SYS_AIS_CTRL: m7 <= CPU_WDATA[2];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // alarm levels, one cycle after their causes
  // ****************************************************************
  oom_level_a: assert property (OOM_ALARM == $past(run && oc))
    else $error("oom alarm wrong");
  ais_level_a: assert property (AIS_ALARM ==
    $past(run && ((en[0] & RX_LINE_AIS) | (en[1] & RX_S16_AIS))))
    else $error("ais alarm wrong");
  mf_alarm_a: assert property (REMOTE_MF_ALARM_TX == $past(run && (m6 | (en[7] & oc))))
    else $error("multiframe alarm wrong");
  ra_alarm_a: assert property (REMOTE_ALARM_TX ==
    $past(run && (m7 | (en[6] & RX_FRAME_LOSS))))
    else $error("remote alarm wrong");
  frame_ins_a: assert property (TX_FRAME_OUT == ($past(run && TX_FRAME_IN) |
    ($past(TX_Y_BIT_SLOT) & REMOTE_MF_ALARM_TX) | ($past(TX_RA_BIT_SLOT) & REMOTE_ALARM_TX)))
    else $error("frame insertion wrong");
  status_set_a: assert property ($rose(REMOTE_ALARM_STATUS) |->
    $past(run && ((en[5] & RX_SLOT0_REMOTE_SEEN) | (en[4] & RX_SLOT16_REMOTE_SEEN))))
    else $error("remote status set without cause");

  // ****************************************************************
  // line paths and soft reset hold
  // ****************************************************************
  tx_line_a: assert property (TX_LINE_OUT ==
    $past(run && (c5[1] ? RX_LINE_IN : (c5[2] | TX_LINE_IN))))
    else $error("line output wrong");
  rx_line_a: assert property (RX_LINE_OUT == $past(run && (c5[0] ? TX_LINE_IN : RX_LINE_IN)))
    else $error("receive path wrong");
  soft_hold_a: assert property ($past(CHANNEL_IN_RESET) |-> !OOM_ALARM && !AIS_ALARM)
    else $error("alarm during soft reset");
endmodule : ealc_chk

bind ealc_ctrl ealc_chk u_chk (.*);

// file: tb_e1_alarm_response_loopback_ctrl.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for alarm response and loopback control
// ****************************************************************
module tb_e1_alarm_response_loopback_ctrl;
  logic CLOCK, RST, CPU_WR, CPU_RD, RX_FRAME_LOSS, RX_S16_MF_LOSS, RX_CRC_MF_LOSS;
  logic RX_LINE_AIS, RX_S16_AIS, RX_SLOT0_REMOTE_SEEN, RX_SLOT16_REMOTE_SEEN, TX_FRAME_IN;
  logic TX_Y_BIT_SLOT, TX_RA_BIT_SLOT, TX_FRAME_OUT, RX_LINE_IN, TX_LINE_IN, TX_LINE_OUT;
  logic RX_LINE_OUT, REMOTE_MF_ALARM_TX, REMOTE_ALARM_TX, REMOTE_ALARM_STATUS, OOM_ALARM;
  logic AIS_ALARM, CHANNEL_IN_RESET, m6, m7;
  logic [11:0] CPU_ADDR;
  logic [7:0] CPU_WDATA, CPU_RDATA, en, c5, rv, r1, r2, seed, ov;
  logic [6:0] ex;
  int fails, checked;

  ealc_ctrl u_dut (.*);
  ealc_far_end u_far (.clock(CLOCK), .rst(RST), .line_out(RX_LINE_IN));

  // next random byte: eight steps of the shift register
  function automatic logic [7:0] roll();
    repeat (8) seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : roll

  // expected {mf, ra, oom, ais, tx line, rx line, frame} from the shadow registers
  function automatic logic [6:0] expect_out();
    logic oc, mf, ra;
    oc = (en[3] & RX_CRC_MF_LOSS) | (en[2] & RX_S16_MF_LOSS);
    mf = m6 | (en[7] & oc);
    ra = m7 | (en[6] & RX_FRAME_LOSS);
    return {mf, ra, oc, (en[0] & RX_LINE_AIS) | (en[1] & RX_S16_AIS),
      c5[1] ? RX_LINE_IN : (c5[2] | TX_LINE_IN), c5[0] ? TX_LINE_IN : RX_LINE_IN,
      TX_FRAME_IN | (TX_Y_BIT_SLOT & mf) | (TX_RA_BIT_SLOT & ra)};
  endfunction : expect_out

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  // register cycles: strobes raised and dropped at falling edges
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    {CPU_ADDR, CPU_WDATA, CPU_WR} = {a, d, 1'b1};
    @(negedge CLOCK);
    CPU_WR = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(negedge CLOCK);
    {CPU_ADDR, CPU_RD} = {a, 1'b1};
    @(negedge CLOCK);
    CPU_RD = 1'b0;
    rv = CPU_RDATA;
  endtask : rd

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // clock and watchdog
  initial
  begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    {CPU_WR, CPU_RD, CPU_ADDR, CPU_WDATA, en, c5, m6, m7} = 40'h00_0000_0000;
    {RX_FRAME_LOSS, RX_S16_MF_LOSS, RX_CRC_MF_LOSS, RX_LINE_AIS, RX_S16_AIS} = 5'h00;
    {RX_SLOT0_REMOTE_SEEN, RX_SLOT16_REMOTE_SEEN, TX_FRAME_IN} = 3'h0;
    {TX_Y_BIT_SLOT, TX_RA_BIT_SLOT, TX_LINE_IN} = 3'h0;
    {fails, checked, seed, RST} = {32'h0000_0000, 32'h0000_0000, 8'h58, 1'b1};
    repeat (2) @(negedge CLOCK);
    RST = 1'b0;
    rd(ealc_pkg::ADDR_ALARM_EN);
    chk(rv, ealc_pkg::RESET_BYTE);
    rd(12'h01ff);
    chk(rv, 8'h00);
    wr(ealc_pkg::ADDR_RESET_LOOP, 8'h7f);
    rd(ealc_pkg::ADDR_RESET_LOOP);
    chk(rv, 8'h07);
    wr(ealc_pkg::ADDR_RESET_LOOP, 8'h00);
    $display("register test done");
    // random conditions, line bits and control writes, checked a cycle later
    for (int i = 0; i < 400; i++)
    begin
      @(negedge CLOCK);
      ov = {1'h0, REMOTE_MF_ALARM_TX, REMOTE_ALARM_TX, OOM_ALARM, AIS_ALARM, TX_LINE_OUT,
        RX_LINE_OUT, TX_FRAME_OUT};
      if (i > 0) chk(ov, {1'h0, ex});
      r1 = roll();
      r2 = roll();
      {RX_FRAME_LOSS, RX_S16_MF_LOSS, RX_CRC_MF_LOSS, RX_LINE_AIS, RX_S16_AIS} = r1[7:3];
      {RX_SLOT0_REMOTE_SEEN, RX_SLOT16_REMOTE_SEEN, TX_FRAME_IN} = r1[2:0];
      // the two marked bit positions never fall on the same bit
      {TX_Y_BIT_SLOT, TX_RA_BIT_SLOT, TX_LINE_IN} = {r2[7], r2[6] & ~r2[7], r2[5]};
      CPU_WDATA = roll() & 8'h7f; // never a soft reset here
      CPU_WR = r2[0] & r2[1];
      CPU_ADDR = r2[2] ? (r2[3] ? ealc_pkg::ADDR_ALARM_EN : ealc_pkg::ADDR_RESET_LOOP)
        : (r2[3] ? ealc_pkg::ADDR_TEST_CTRL : ealc_pkg::ADDR_SYS_AIS_CTRL);
      ex = expect_out();
      if (CPU_WR)
      begin
        if (CPU_ADDR == ealc_pkg::ADDR_ALARM_EN) en = CPU_WDATA;
        if (CPU_ADDR == ealc_pkg::ADDR_RESET_LOOP) c5 = CPU_WDATA & ealc_pkg::MASK_RESET_LOOP;
        if (CPU_ADDR == ealc_pkg::ADDR_TEST_CTRL) m6 = CPU_WDATA[5];
        if (CPU_ADDR == ealc_pkg::ADDR_SYS_AIS_CTRL) m7 = CPU_WDATA[2];
      end
    end
    @(negedge CLOCK);
    {CPU_WR, TX_Y_BIT_SLOT, TX_RA_BIT_SLOT, TX_LINE_IN, TX_FRAME_IN} = 5'h00;
    {RX_FRAME_LOSS, RX_S16_MF_LOSS, RX_CRC_MF_LOSS, RX_LINE_AIS, RX_S16_AIS} = 5'h00;
    {RX_SLOT0_REMOTE_SEEN, RX_SLOT16_REMOTE_SEEN} = 2'h0;
    rd(ealc_pkg::ADDR_STATUS);
    $display("random test done");
    // sticky remote status: each source with its enable, and one without
    for (int k = 0; k < 3; k++)
    begin
      wr(ealc_pkg::ADDR_ALARM_EN, (k == 0) ? 8'h20 : 8'h10);
      {RX_SLOT0_REMOTE_SEEN, RX_SLOT16_REMOTE_SEEN} = (k == 1) ? 2'h1 : 2'h2;
      @(negedge CLOCK);
      {RX_SLOT0_REMOTE_SEEN, RX_SLOT16_REMOTE_SEEN} = 2'h0;
      chk({7'h00, REMOTE_ALARM_STATUS}, (k == 2) ? 8'h00 : 8'h01);
      rd(ealc_pkg::ADDR_STATUS);
      chk(rv, (k == 2) ? 8'h00 : 8'h10);
      rd(ealc_pkg::ADDR_STATUS);
      chk(rv, 8'h00);
    end
    $display("status test done");
    // soft reset holds alarms low, keeps controls, and releases on a zero write
    wr(ealc_pkg::ADDR_ALARM_EN, 8'h0f);
    {RX_CRC_MF_LOSS, RX_LINE_AIS} = 2'h3;
    wr(ealc_pkg::ADDR_RESET_LOOP, 8'h80);
    @(negedge CLOCK);
    chk({5'h00, CHANNEL_IN_RESET, OOM_ALARM, AIS_ALARM}, 8'h04);
    rd(ealc_pkg::ADDR_ALARM_EN);
    chk(rv, 8'h0f);
    wr(ealc_pkg::ADDR_RESET_LOOP, 8'h00);
    @(negedge CLOCK);
    chk({5'h00, CHANNEL_IN_RESET, OOM_ALARM, AIS_ALARM}, 8'h03);
    rd(ealc_pkg::ADDR_STATUS);
    chk(rv, 8'h0c);
    $display("soft reset test done");
    tally_and_finish();
  end
endmodule : tb_e1_alarm_response_loopback_ctrl
